// ==== logic/countdown_pkg.sv ====
// constants and types shared by the pedestrian clearance countdown
package countdown_pkg;

    // clock rate and the derived cycle counts
    localparam int unsigned CLK_KHZ    = 100_000;
    localparam int unsigned SEC_MS     = 1000;
    localparam int unsigned STEADY_MS  = 1000;
    localparam int unsigned DARK_MS    = 1000;
    localparam int unsigned LOSS_MS    = 1500;
    localparam int unsigned SEC_CYC    = SEC_MS * CLK_KHZ;
    localparam int unsigned STEADY_CYC = STEADY_MS * CLK_KHZ;
    localparam int unsigned DARK_CYC   = DARK_MS * CLK_KHZ;
    localparam int unsigned LOSS_CYC   = LOSS_MS * CLK_KHZ;

    // widths
    localparam int unsigned CNT_W = 28;
    localparam int unsigned SEC_W = 8;
    localparam int unsigned SEG_W = 7;

    // seconds values
    localparam logic [SEC_W-1:0] TOL_SEC  = 8'h01;
    localparam logic [SEC_W-1:0] DISP_MAX = 8'h63;
    localparam logic [SEC_W-1:0] SEC_ZERO = 8'h00;
    localparam logic [SEC_W-1:0] SEC_ONE  = 8'h01;
    localparam logic [SEC_W-1:0] SEC_TEN  = 8'h0a;

    // segment patterns, bit order g f e d c b a
    localparam logic [SEG_W-1:0] SEG_OFF = 7'h00;

    typedef enum logic [1:0] {
        PH_OFF,
        PH_WALK,
        PH_FLASH
    } phase_e;

endpackage

// ==== logic/second_tick.sv ====
// restartable one-second tick generator
`timescale 1ns/1ps
module second_tick #(
    parameter int unsigned PERIOD = countdown_pkg::SEC_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic restart,
    output logic      tick
);

    typedef struct packed {
        logic [countdown_pkg::CNT_W-1:0] cnt;
        logic                            tick;
    } tick_s;

    tick_s st_ff;
    tick_s nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        // restart wins so a phase edge always starts a whole second
        if (restart)
        begin
            nxt_st.cnt = '0;
        end
        else if (st_ff.cnt == countdown_pkg::CNT_W'(PERIOD - 1))
        begin
            nxt_st.cnt = '0;
            nxt_st.tick = 1'b1;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + countdown_pkg::CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;

endmodule

// ==== logic/pedestrian_clearance_countdown.sv ====
// pedestrian clearance countdown: learns the flashing-hand time and shows it
//
// Contract
// (RL1) count down learned time from flashing hand start; zero and blank at steady hand
// (RL2) one behaviour only: clearance countdown, no other display modes
// (RL3) no user inputs alter timing; all timing comes from observed indications
// (RL4) after power-up one automatic learning cycle with digits dark
// (RL5) timing change blanks digits at once, then one dark cycle relearns
// (RL6) walk cut short: follow to flashing hand and count from its start
// (RL7) preemption during flashing hand: keep counting without pause or restart
// (RL8) cycle after preemption uses learned timing; preemption is no timing change
// (RL9) steady hand before zero, or both symbols dark: stop timing, digits dark
// (RL10) supply loss over 1.5 s keeps digits dark for one whole cycle
// (RL11) remaining time shown on tens and units seven-segment digits
// (RL12) constant drive whenever powered, no dimming
// (RL13) supply loss turns all segment outputs off immediately
// (RL14) flashing-hand time measured in whole seconds; count decrements once a second
`timescale 1ns/1ps
module pedestrian_clearance_countdown #(
    parameter int unsigned SEC_CYC    = countdown_pkg::SEC_CYC,
    parameter int unsigned STEADY_CYC = countdown_pkg::STEADY_CYC,
    parameter int unsigned DARK_CYC   = countdown_pkg::DARK_CYC,
    parameter int unsigned LOSS_CYC   = countdown_pkg::LOSS_CYC
) (
    input  wire logic                            ref_clk,
    input  wire logic                            rst_b,
    input  wire logic                            walk_lamp,
    input  wire logic                            hand_lamp,
    input  wire logic                            supply_ok,
    output logic [countdown_pkg::SEG_W-1:0]      seg_tens,
    output logic [countdown_pkg::SEG_W-1:0]      seg_units
);

    typedef struct packed {
        countdown_pkg::phase_e                ph;
        logic                                 learned;
        logic                                 measuring;
        logic                                 preempt;
        logic                                 show;
        logic                                 walk_prev;
        logic                                 hand_prev;
        logic [countdown_pkg::SEC_W-1:0]      walk_len;
        logic [countdown_pkg::SEC_W-1:0]      flash_len;
        logic [countdown_pkg::SEC_W-1:0]      walk_sec;
        logic [countdown_pkg::SEC_W-1:0]      flash_sec;
        logic [countdown_pkg::SEC_W-1:0]      last_rise;
        logic [countdown_pkg::SEC_W-1:0]      count;
        logic [countdown_pkg::CNT_W-1:0]      on_cnt;
        logic [countdown_pkg::CNT_W-1:0]      off_cnt;
        logic [countdown_pkg::CNT_W-1:0]      loss_cnt;
        logic [countdown_pkg::SEG_W-1:0]      seg_tens;
        logic [countdown_pkg::SEG_W-1:0]      seg_units;
    } state_s;

    state_s st_ff;
    state_s nxt_st;
    logic   tick;
    logic   walk_rise;
    logic   flash_start;
    logic   restart;

    function automatic logic [countdown_pkg::SEC_W-1:0] sat_inc8(
        input logic [countdown_pkg::SEC_W-1:0] v
    );
        return (v == '1) ? v : v + countdown_pkg::SEC_ONE;
    endfunction

    function automatic logic [countdown_pkg::CNT_W-1:0] sat_inc28(
        input logic [countdown_pkg::CNT_W-1:0] v
    );
        return (v == '1) ? v : v + countdown_pkg::CNT_W'(1);
    endfunction

    // differences of one second are jitter between lamp edges and the tick
    function automatic logic differs(
        input logic [countdown_pkg::SEC_W-1:0] a,
        input logic [countdown_pkg::SEC_W-1:0] b
    );
        logic [countdown_pkg::SEC_W-1:0] d;
        d = (a > b) ? a - b : b - a;
        return d > countdown_pkg::TOL_SEC;
    endfunction

    function automatic logic [countdown_pkg::SEG_W-1:0] seg7(
        input logic [3:0] d
    );
        logic [countdown_pkg::SEG_W-1:0] s;
        case (d)
            4'h0: s = 7'h3f;
            4'h1: s = 7'h06;
            4'h2: s = 7'h5b;
            4'h3: s = 7'h4f;
            4'h4: s = 7'h66;
            4'h5: s = 7'h6d;
            4'h6: s = 7'h7d;
            4'h7: s = 7'h07;
            4'h8: s = 7'h7f;
            4'h9: s = 7'h6f;
            default: s = countdown_pkg::SEG_OFF;
        endcase
        return s;
    endfunction

    // longer clearances than two digits hold at 99
    function automatic logic [countdown_pkg::SEC_W-1:0] clamp99(
        input logic [countdown_pkg::SEC_W-1:0] v
    );
        return (v > countdown_pkg::DISP_MAX) ? countdown_pkg::DISP_MAX : v;
    endfunction

    // (RL3) timing from lamps only
    assign walk_rise   = walk_lamp & ~st_ff.walk_prev;
    assign flash_start = (st_ff.ph == countdown_pkg::PH_WALK) & ~walk_lamp & hand_lamp & supply_ok;
    assign restart     = walk_rise | flash_start;

    // (RL14) whole-second timebase
    second_tick #(
        .PERIOD (SEC_CYC)
    ) u_tick (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .restart (restart),
        .tick    (tick)
    );

    always_comb
    begin
        logic                            steady;
        logic                            dark;
        logic                            hand_rise;
        logic                            change;
        logic [countdown_pkg::SEC_W-1:0] disp;
        nxt_st = st_ff;
        steady = st_ff.on_cnt >= countdown_pkg::CNT_W'(STEADY_CYC);
        dark = st_ff.off_cnt >= countdown_pkg::CNT_W'(DARK_CYC);
        hand_rise = hand_lamp & ~st_ff.hand_prev;
        change = 1'b0;
        disp = countdown_pkg::SEC_ZERO;
        nxt_st.walk_prev = walk_lamp;
        nxt_st.hand_prev = hand_lamp;
        nxt_st.on_cnt = hand_lamp ? sat_inc28(st_ff.on_cnt) : '0;
        nxt_st.off_cnt = (!hand_lamp && !walk_lamp) ? sat_inc28(st_ff.off_cnt) : '0;
        if (!supply_ok)
        begin
            // (RL13) dark at once on supply loss
            nxt_st.loss_cnt = sat_inc28(st_ff.loss_cnt);
            nxt_st.ph = countdown_pkg::PH_OFF;
            nxt_st.show = 1'b0;
        end
        else
        begin
            nxt_st.loss_cnt = '0;
            if (st_ff.loss_cnt > countdown_pkg::CNT_W'(LOSS_CYC))
            begin
                // (RL10) long outage forgets timing
                nxt_st.learned = 1'b0;
                nxt_st.measuring = 1'b0;
                nxt_st.ph = countdown_pkg::PH_OFF;
                nxt_st.show = 1'b0;
            end
            else if (walk_rise)
            begin
                // (RL4) unlearned cycles are measured dark
                nxt_st.ph = countdown_pkg::PH_WALK;
                nxt_st.walk_sec = countdown_pkg::SEC_ZERO;
                nxt_st.show = 1'b0;
                nxt_st.measuring = ~st_ff.learned;
            end
            else
            begin
                case (st_ff.ph)
                    countdown_pkg::PH_WALK:
                    begin
                        if (dark)
                        begin
                            nxt_st.ph = countdown_pkg::PH_OFF;
                        end
                        else if (flash_start)
                        begin
                            // (RL6) flash start ends walk, even a short one
                            nxt_st.ph = countdown_pkg::PH_FLASH;
                            nxt_st.flash_sec = countdown_pkg::SEC_ZERO;
                            nxt_st.last_rise = countdown_pkg::SEC_ZERO;
                            // (RL8) short walk marks a preempted cycle
                            nxt_st.preempt = st_ff.learned && (st_ff.walk_sec < st_ff.walk_len)
                                             && differs(st_ff.walk_sec, st_ff.walk_len);
                            // (RL1) load learned clearance
                            nxt_st.count = st_ff.learned ? st_ff.flash_len : countdown_pkg::SEC_ZERO;
                            nxt_st.show = st_ff.learned;
                        end
                        else
                        begin
                            if (tick)
                            begin
                                nxt_st.walk_sec = sat_inc8(st_ff.walk_sec);
                            end
                            // (RL5) walk grew longer
                            if (st_ff.learned && st_ff.walk_sec > st_ff.walk_len
                                && differs(st_ff.walk_sec, st_ff.walk_len))
                            begin
                                change = 1'b1;
                            end
                        end
                    end
                    countdown_pkg::PH_FLASH:
                    begin
                        if (dark)
                        begin
                            // (RL9) both symbols dark
                            nxt_st.ph = countdown_pkg::PH_OFF;
                            nxt_st.show = 1'b0;
                        end
                        else if (steady)
                        begin
                            // (RL9) steady hand stops timing and blanks
                            nxt_st.ph = countdown_pkg::PH_OFF;
                            nxt_st.show = 1'b0;
                            if (st_ff.measuring)
                            begin
                                // (RL14) store learned whole seconds
                                nxt_st.walk_len = st_ff.walk_sec;
                                nxt_st.flash_len = st_ff.last_rise;
                                nxt_st.learned = 1'b1;
                                nxt_st.measuring = 1'b0;
                            end
                            // (RL8) preempted cycle never relearns from a short flash
                            else if (st_ff.learned && !st_ff.preempt
                                     && differs(st_ff.last_rise, st_ff.flash_len))
                            begin
                                change = 1'b1;
                            end
                        end
                        else
                        begin
                            // a rise on a whole second lands one edge before its own tick
                            if (hand_rise)
                            begin
                                nxt_st.last_rise = sat_inc8(st_ff.flash_sec);
                            end
                            // (RL7) counting never paused inside the flash
                            if (tick)
                            begin
                                nxt_st.flash_sec = sat_inc8(st_ff.flash_sec);
                                if (st_ff.count != countdown_pkg::SEC_ZERO)
                                begin
                                    nxt_st.count = st_ff.count - countdown_pkg::SEC_ONE;
                                end
                            end
                            // (RL5) flash outlasted the learned time
                            if (st_ff.learned && st_ff.flash_sec > st_ff.flash_len
                                && differs(st_ff.flash_sec, st_ff.flash_len))
                            begin
                                change = 1'b1;
                            end
                        end
                    end
                    default:
                    begin
                        nxt_st.show = 1'b0;
                    end
                endcase
            end
            if (change)
            begin
                // (RL5) blank now, relearn on next full cycle
                nxt_st.learned = 1'b0;
                nxt_st.measuring = 1'b0;
                nxt_st.show = 1'b0;
            end
        end
        // (RL2) single countdown view, nothing else selectable
        disp = clamp99(nxt_st.count);
        // (RL11) tens blank when zero, units always lit while shown
        if (nxt_st.show && supply_ok)
        begin
            nxt_st.seg_units = seg7(4'(disp % countdown_pkg::SEC_TEN));
            nxt_st.seg_tens = (disp < countdown_pkg::SEC_TEN) ? countdown_pkg::SEG_OFF
                              : seg7(4'(disp / countdown_pkg::SEC_TEN));
        end
        else
        begin
            nxt_st.seg_units = countdown_pkg::SEG_OFF;
            nxt_st.seg_tens = countdown_pkg::SEG_OFF;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // (RL12) static levels, no pwm, so drive never dims
    assign seg_tens  = st_ff.seg_tens;
    assign seg_units = st_ff.seg_units;

endmodule

// ==== verification/countdown_assertions.sv ====
// concurrent checks on the countdown display outputs
`timescale 1ns/1ps
module countdown_checker #(
    parameter int unsigned SEC_CYC    = 10,
    parameter int unsigned STEADY_CYC = 15,
    parameter int unsigned DARK_CYC   = 15
) (
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic       walk_lamp,
    input wire logic       hand_lamp,
    input wire logic       supply_ok,
    input wire logic [6:0] seg_tens,
    input wire logic [6:0] seg_units
);
    localparam logic [6:0] PAT [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
    int unsigned dark_cnt;
    int unsigned on_cnt;
    int unsigned hold_cnt;
    logic [13:0] prev_seg;

    // shown value of both digits, dark digits count as zero
    function automatic int unsigned val(input logic [13:0] s);
        int unsigned r;
        r = 0;
        for (int i = 0; i < 10; i++)
        begin
            if (s[13:7] == PAT[i])
                r = r + 10 * i;
            if (s[6:0] == PAT[i])
                r = r + i;
        end
        return r;
    endfunction

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dark_cnt <= 0;
            on_cnt   <= 0;
            hold_cnt <= 0;
            prev_seg <= '0;
        end
        else
        begin
            dark_cnt <= (walk_lamp || hand_lamp) ? 0 : dark_cnt + 1;
            on_cnt   <= hand_lamp ? on_cnt + 1 : 0;
            hold_cnt <= ({seg_tens, seg_units} == prev_seg) ? hold_cnt + 1 : 0;
            prev_seg <= {seg_tens, seg_units};
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_blank;
        seg_tens == 7'h00 && seg_units == 7'h00;
    endsequence
    sequence s_lit_change;
        seg_units != 7'h00 && prev_seg[6:0] != 7'h00 && {seg_tens, seg_units} != prev_seg;
    endsequence

    property p_supply_blank;
        !supply_ok |-> ##2 s_blank;
    endproperty
    property p_walk_blank;
        walk_lamp |-> ##1 s_blank;
    endproperty
    // margin of two cycles for input and output registers
    property p_dark_blank;
        dark_cnt >= DARK_CYC + 2 |-> s_blank;
    endproperty
    property p_steady_blank;
        on_cnt >= STEADY_CYC + 3 |-> s_blank;
    endproperty
    property p_step;
        s_lit_change |-> val({seg_tens, seg_units}) + 1 == val(prev_seg);
    endproperty
    property p_hold;
        s_lit_change |-> hold_cnt + 2 >= SEC_CYC && hold_cnt <= SEC_CYC;
    endproperty
    property p_digits;
        (seg_units == 7'h00 || seg_units == PAT[val({7'h00, seg_units})])
        && (seg_tens == 7'h00 || (seg_tens != PAT[0] && seg_tens == PAT[val({7'h00, seg_tens})]));
    endproperty
    property p_tens_pair;
        seg_tens != 7'h00 |-> seg_units != 7'h00;
    endproperty

    a_supply_blank: assert property (p_supply_blank) else $error("digits lit without supply");
    a_walk_blank: assert property (p_walk_blank) else $error("digits lit during walk");
    a_dark_blank: assert property (p_dark_blank) else $error("digits lit with both lamps dark");
    a_steady_blank: assert property (p_steady_blank) else $error("digits lit at steady hand");
    a_step: assert property (p_step) else $error("count did not step down by one");
    a_hold: assert property (p_hold) else $error("count step not one second apart");
    a_digits: assert property (p_digits) else $error("illegal segment pattern");
    a_tens_pair: assert property (p_tens_pair) else $error("tens lit with units dark");
endmodule

// ==== verification/controller_model.sv ====
// signal controller model driving the pedestrian lamps
`timescale 1ns/1ps
module controller_model #(
    parameter int unsigned SEC_CYC = 10
) (
    input wire logic ref_clk,
    output logic     walk_lamp,
    output logic     hand_lamp
);
    initial
    begin
        walk_lamp = 1'b0;
        hand_lamp = 1'b0;
    end

    task automatic show(input logic w, input logic h, input int unsigned n);
        walk_lamp = w;
        hand_lamp = h;
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic walk(input int unsigned secs);
        show(1'b1, 1'b0, secs * SEC_CYC);
    endtask

    // half-second flashes keep gaps under the dark threshold
    task automatic flash(input int unsigned secs);
        repeat (secs)
        begin
            show(1'b0, 1'b1, SEC_CYC / 2);
            show(1'b0, 1'b0, SEC_CYC - SEC_CYC / 2);
        end
    endtask

    task automatic steady(input int unsigned n);
        show(1'b0, 1'b1, n);
    endtask

    task automatic dark(input int unsigned n);
        show(1'b0, 1'b0, n);
    endtask
endmodule

// ==== verification/test_pedestrian_clearance_countdown.sv ====
// self-checking bench for the pedestrian clearance countdown
`timescale 1ns/1ps
module test_pedestrian_clearance_countdown;
    localparam int unsigned SEC_CYC    = 10;
    localparam int unsigned STEADY_CYC = 15;
    localparam int unsigned DARK_CYC   = 15;
    localparam int unsigned LOSS_CYC   = 20;
    localparam logic [6:0] PAT [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
    logic                            ref_clk;
    logic                            rst_b;
    logic                            supply_ok;
    wire logic                       walk_lamp;
    wire logic                       hand_lamp;
    logic [countdown_pkg::SEG_W-1:0] seg_tens;
    logic [countdown_pkg::SEG_W-1:0] seg_units;
    int                              num_errors;
    int                              n_compared;

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    pedestrian_clearance_countdown #(
        .SEC_CYC    (SEC_CYC),
        .STEADY_CYC (STEADY_CYC),
        .DARK_CYC   (DARK_CYC),
        .LOSS_CYC   (LOSS_CYC)
    ) pedestrian_clearance_countdown_i (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .walk_lamp (walk_lamp),
        .hand_lamp (hand_lamp),
        .supply_ok (supply_ok),
        .seg_tens  (seg_tens),
        .seg_units (seg_units)
    );

    controller_model #(
        .SEC_CYC (SEC_CYC)
    ) controller_model_i (
        .ref_clk   (ref_clk),
        .walk_lamp (walk_lamp),
        .hand_lamp (hand_lamp)
    );

    task automatic check_seg(input int unsigned v, input bit lit);
        logic [6:0] et;
        logic [6:0] eu;
        et = (lit && v >= 10) ? PAT[v / 10] : countdown_pkg::SEG_OFF;
        eu = lit ? PAT[v % 10] : countdown_pkg::SEG_OFF;
        n_compared++;
        if (seg_tens !== et || seg_units !== eu)
        begin
            num_errors++;
            $display("mismatch at %0t: digits %h %h, want %h %h", $time, seg_tens, seg_units, et, eu);
        end
    endtask

    // walk, flashing hand checked each second except second lrn+1 when on, steady hand
    task automatic ped_cycle(input int unsigned w, input int unsigned f, input int unsigned lrn, input bit on);
        controller_model_i.walk(w);
        check_seg(0, 1'b0);
        fork
            controller_model_i.flash(f);
            for (int k = 0; k < f; k++)
            begin
                repeat (SEC_CYC / 2) @(negedge ref_clk);
                if (!on || k > lrn + 1)
                    check_seg(0, 1'b0);
                else if (k <= lrn)
                    check_seg(lrn - k, 1'b1);
                repeat (SEC_CYC / 2) @(negedge ref_clk);
            end
        join
        fork
            controller_model_i.steady(3 * STEADY_CYC);
            begin
                repeat (SEC_CYC / 2) @(negedge ref_clk);
                if (on && f == lrn)
                    check_seg(0, 1'b1);
                repeat (STEADY_CYC + 5) @(negedge ref_clk);
                check_seg(0, 1'b0);
            end
        join
    endtask

    task automatic test_power_up;
        check_seg(0, 1'b0);
        rst_b = 1'b1;
        ped_cycle(3, 5, 5, 1'b0);
        ped_cycle(3, 5, 5, 1'b1);
    endtask

    task automatic test_preempt;
        ped_cycle(1, 5, 5, 1'b1);
        ped_cycle(3, 5, 5, 1'b1);
        ped_cycle(1, 2, 5, 1'b1);
        ped_cycle(3, 5, 5, 1'b1);
    endtask

    task automatic test_timing_change;
        ped_cycle(3, 8, 5, 1'b1);
        ped_cycle(3, 8, 8, 1'b0);
        ped_cycle(3, 8, 8, 1'b1);
    endtask

    // long supply loss mid-countdown forces a dark relearn
    task automatic test_power_loss;
        controller_model_i.walk(3);
        fork
            controller_model_i.flash(3);
            begin
                repeat (15) @(negedge ref_clk);
                check_seg(7, 1'b1);
                supply_ok = 1'b0;
                repeat (2) @(negedge ref_clk);
                check_seg(0, 1'b0);
                repeat (LOSS_CYC + 3) @(negedge ref_clk);
                supply_ok = 1'b1;
            end
        join
        controller_model_i.steady(3 * STEADY_CYC);
        ped_cycle(3, 5, 5, 1'b0);
        ped_cycle(3, 5, 5, 1'b1);
    endtask

    task automatic test_lamps_dark;
        controller_model_i.walk(3);
        controller_model_i.flash(2);
        controller_model_i.dark(DARK_CYC + 5);
        check_seg(0, 1'b0);
    endtask

    task automatic print_verdict;
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        rst_b = 1'b0;
        supply_ok = 1'b1;
        num_errors = 0;
        n_compared = 0;
        repeat (20) @(negedge ref_clk);
        test_power_up();
        test_preempt();
        test_timing_change();
        test_power_loss();
        test_lamps_dark();
        print_verdict();
    end

    // the whole run needs about 1600 cycles
    initial
    begin
        #100_000;
        num_errors++;
        $display("mismatch at %0t: run did not finish", $time);
        print_verdict();
    end
endmodule

bind pedestrian_clearance_countdown countdown_checker #(
    .SEC_CYC    (SEC_CYC),
    .STEADY_CYC (STEADY_CYC),
    .DARK_CYC   (DARK_CYC)
) countdown_checker_i (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .walk_lamp (walk_lamp),
    .hand_lamp (hand_lamp),
    .supply_ok (supply_ok),
    .seg_tens  (seg_tens),
    .seg_units (seg_units)
);
